// ===== sarrd_pkg.sv
// Constants and state encoding for the converter sequencing block
package sarrd_pkg;
   localparam int RESULT_BITS = 16;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_TIME_NS = 4700;
   // Longest time rounds down to whole cycles
   localparam int CONV_MAX_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam logic [1:0] STEP_DIV_LAST = 2'h3;
   localparam logic [3:0] MSB_INDEX = 4'hf;
   localparam logic [15:0] SAR_FIRST_TRIAL = 16'h8000;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [7:0] BUS_RESET = 8'h00;

   typedef enum logic [5:0] {
      SARRD_SHUTDOWN = 6'h01,
      SARRD_STANDBY = 6'h02,
      SARRD_ACQUIRE = 6'h04,
      SARRD_CONVERT = 6'h08,
      SARRD_DONE = 6'h10,
      SARRD_READ = 6'h20
   } sarrd_state_t;
endpackage : sarrd_pkg

// ===== sarrd_top.sv
// Sequencer, SAR register and byte-wide readout of the converter
//
// What this block and its host must do
// R1: Drive end-of-conversion flag low once conversion finishes and result is valid.
// R2: Present the 16-bit result on tri-state parallel outputs.
// R3: Keep result outputs high impedance throughout acquisition and conversion.
// R4: Third strobe fall with select high drives result after output delay.
// R5: Raising the strobe after a read releases the result bus.
// R6: After a read, stay idle until the next strobe falling edge.
// R7: Upper-byte select low gives low byte, high gives high byte.
// R8: Result is straight unsigned binary, zero for lowest input.
// R9: Host switches input channel right after acquisition ends.
// R10: First strobe fall with select low powers up and acquires; high is ignored.
// R11: Second fall starts conversion; select picks standby or shutdown afterwards.
// R12: Conversion completes within the maximum conversion time after second fall.
// R13: Host waits reference settling time after shutdown before converting.
// R14: Host waits for end-of-conversion before the reading strobe fall.
`timescale 1ns/1ps
module sarrd_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Host control
   input wire logic convert_strobe_n,
   input wire logic read_select,
   input wire logic upper_byte_select,
   // Analog front end
   input wire logic comparator_high,
   output logic [15:0] dac_code,
   output logic track_hold,
   output logic reference_on,
   // Host status and data
   output logic eoc_n,
   output logic [7:0] result_bus_out,
   output logic result_bus_oe
);
   ////////////////////////////////////////////////////////////////////////////
   localparam int conv_max = sarrd_pkg::CONV_MAX_CYCLES;

   sarrd_pkg::sarrd_state_t state;
   logic strobe_prev;
   logic strobe_fall;
   logic shutdown_mode;
   logic [1:0] div_cnt;
   logic step_en;
   logic [3:0] bit_idx;
   logic [15:0] result;

   // Trial bit is kept only if the input is at or above the trial code
   function automatic logic [15:0] sar_step(input logic [15:0] code, input logic [3:0] idx,
                                            input logic keep);
      logic [15:0] c;
      c = code;
      c[idx] = keep;
      if (idx != 4'h0) begin
         c[idx - 4'h1] = 1'b1;
      end
      return c;
   endfunction : sar_step

   assign strobe_fall = strobe_prev & ~convert_strobe_n;
   assign step_en = (div_cnt == sarrd_pkg::STEP_DIV_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // Strobe edge detection; inputs are synchronous to ref_clk
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strobe_prev <= 1'b1;
      end else begin
         strobe_prev <= convert_strobe_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= sarrd_pkg::SARRD_SHUTDOWN;
         shutdown_mode <= 1'b1;
      end else begin
         case (state)
            sarrd_pkg::SARRD_SHUTDOWN, sarrd_pkg::SARRD_STANDBY: begin
               if (strobe_fall && !read_select) begin // see R10 see R6
                  state <= sarrd_pkg::SARRD_ACQUIRE;
               end
            end
            sarrd_pkg::SARRD_ACQUIRE: begin
               if (strobe_fall) begin // see R11
                  state <= sarrd_pkg::SARRD_CONVERT;
                  shutdown_mode <= read_select;
               end
            end
            sarrd_pkg::SARRD_CONVERT: begin
               if (step_en && bit_idx == 4'h0) begin // see R12
                  state <= sarrd_pkg::SARRD_DONE;
               end
            end
            sarrd_pkg::SARRD_DONE: begin
               // A reading edge with the select low is simply ignored
               if (strobe_fall && read_select) begin // see R4
                  state <= sarrd_pkg::SARRD_READ;
               end
            end
            sarrd_pkg::SARRD_READ: begin
               if (convert_strobe_n) begin // see R5 see R6
                  state <= shutdown_mode ? sarrd_pkg::SARRD_SHUTDOWN : sarrd_pkg::SARRD_STANDBY;
               end
            end
            default: begin
               state <= sarrd_pkg::SARRD_SHUTDOWN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Self-timed step clock; four ref_clk cycles a bit keeps 16 bits well inside the limit
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div_cnt <= 2'h0;
      end else if (state == sarrd_pkg::SARRD_CONVERT) begin
         div_cnt <= div_cnt + 2'h1;
      end else begin
         div_cnt <= 2'h0;
      end
   end

   // Successive approximation register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dac_code <= sarrd_pkg::SAR_FIRST_TRIAL;
         bit_idx <= sarrd_pkg::MSB_INDEX;
         result <= sarrd_pkg::RESULT_RESET;
      end else if (state == sarrd_pkg::SARRD_ACQUIRE) begin
         dac_code <= sarrd_pkg::SAR_FIRST_TRIAL;
         bit_idx <= sarrd_pkg::MSB_INDEX;
      end else if (state == sarrd_pkg::SARRD_CONVERT && step_en) begin
         dac_code <= sar_step(dac_code, bit_idx, comparator_high); // see R8
         bit_idx <= bit_idx - 4'h1;
         if (bit_idx == 4'h0) begin
            result <= sar_step(dac_code, bit_idx, comparator_high); // see R8
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Front-end and status outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         eoc_n <= 1'b1;
         track_hold <= 1'b0;
         reference_on <= 1'b0;
      end else begin
         track_hold <= (state == sarrd_pkg::SARRD_ACQUIRE);
         // Flag stays low through the read and idle until a new acquisition
         if (state == sarrd_pkg::SARRD_ACQUIRE) begin
            eoc_n <= 1'b1;
         end else if (state == sarrd_pkg::SARRD_DONE) begin
            eoc_n <= 1'b0; // see R1
         end
         reference_on <= (state == sarrd_pkg::SARRD_ACQUIRE) || (state == sarrd_pkg::SARRD_CONVERT) ||
                         ((state == sarrd_pkg::SARRD_DONE || state == sarrd_pkg::SARRD_READ ||
                           state == sarrd_pkg::SARRD_STANDBY) && !shutdown_mode); // see R11
      end
   end

   // Result bus; the register stage is the output-enable delay
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         result_bus_oe <= 1'b0;
         result_bus_out <= sarrd_pkg::BUS_RESET;
      end else begin
         result_bus_oe <= (state == sarrd_pkg::SARRD_READ) && !convert_strobe_n; // see R2 see R3 see R5
         result_bus_out <= upper_byte_select ? result[15:8] : result[7:0]; // see R7
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_conv_start;
      state == sarrd_pkg::SARRD_ACQUIRE && strobe_fall;
   endsequence

   sequence s_read_edge;
      state == sarrd_pkg::SARRD_DONE && strobe_fall && read_select;
   endsequence

   sequence s_read_release;
      state == sarrd_pkg::SARRD_READ && convert_strobe_n;
   endsequence

   a_eoc_in_time: assert property (@(posedge ref_clk) disable iff (rst) // see R12
      s_conv_start |-> ##[1:conv_max] !eoc_n) else $error("conversion flag late");

   a_eoc_valid: assert property (@(posedge ref_clk) disable iff (rst) // see R1
      $fell(eoc_n) |-> $past(state) == sarrd_pkg::SARRD_DONE && result == $past(result))
      else $error("flag fell outside done");

   a_bus_hiz_conv: assert property (@(posedge ref_clk) disable iff (rst) // see R3
      (state == sarrd_pkg::SARRD_ACQUIRE || state == sarrd_pkg::SARRD_CONVERT) |-> !result_bus_oe)
      else $error("bus driven during conversion");

   a_read_drives: assert property (@(posedge ref_clk) disable iff (rst) // see R4
      s_read_edge ##1 !convert_strobe_n |-> ##1 result_bus_oe) else $error("read did not drive bus");

   a_read_release: assert property (@(posedge ref_clk) disable iff (rst) // see R5
      s_read_release |=> !result_bus_oe ##1 !result_bus_oe) else $error("bus not released");

   a_idle_after_read: assert property (@(posedge ref_clk) disable iff (rst) // see R6
      s_read_release |=> (state == sarrd_pkg::SARRD_STANDBY || state == sarrd_pkg::SARRD_SHUTDOWN))
      else $error("not idle after read");

   a_byte_select: assert property (@(posedge ref_clk) disable iff (rst) // see R7
      result_bus_oe |-> result_bus_out == ($past(upper_byte_select) ? result[15:8] : result[7:0]))
      else $error("wrong byte on bus");

   a_first_ignored: assert property (@(posedge ref_clk) disable iff (rst) // see R10
      (state == sarrd_pkg::SARRD_SHUTDOWN && strobe_fall && read_select) |=>
      state == sarrd_pkg::SARRD_SHUTDOWN) else $error("ignored edge woke device");

   a_power_mode: assert property (@(posedge ref_clk) disable iff (rst) // see R11
      s_conv_start ##1 (state == sarrd_pkg::SARRD_CONVERT)[*1] ##[1:conv_max]
      (state == sarrd_pkg::SARRD_DONE) |=> reference_on == !shutdown_mode)
      else $error("wrong power mode after conversion");

endmodule : sarrd_top

// ===== sarrd_host.sv
// Host model that sequences the converter through strobe and select levels
`timescale 1ns/1ps
module sarrd_host #(
   parameter int SETTLE_CYCLES = 8
) (
   // Clock
   input wire logic ref_clk,
   // Device status
   input wire logic eoc_n,
   // Host control
   output logic convert_strobe_n,
   output logic read_select,
   output logic upper_byte_select
);
   initial begin
      convert_strobe_n = 1'h1;
      read_select = 1'h0;
      upper_byte_select = 1'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Strobe goes high for a cycle first, so every fall is a fresh edge
   task automatic fall(input logic sel);
      @(posedge ref_clk);
      #1 convert_strobe_n = 1'h1;
      @(posedge ref_clk);
      #1 convert_strobe_n = 1'h0;
      read_select = sel;
   endtask : fall
   task automatic release_bus();
      @(posedge ref_clk);
      #1 convert_strobe_n = 1'h1;
   endtask : release_bus
   // Settling is shortened; a real reference needs far longer
   task automatic settle();
      repeat (SETTLE_CYCLES) @(posedge ref_clk);
   endtask : settle
   task automatic wait_eoc(output int n);
      n = 0;
      while (eoc_n !== 1'h0 && n < 200) begin
         @(posedge ref_clk);
         #1 n++;
      end
   endtask : wait_eoc
   task automatic pick(input logic hi);
      @(posedge ref_clk);
      #1 upper_byte_select = hi;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : pick
endmodule : sarrd_host

// ===== tb.sv
// Self-checking testbench for the converter sequencing block
`timescale 1ns/1ps
module tb;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic [15:0] analog = 16'h0000;
   logic [15:0] held = 16'h0000;
   logic convert_strobe_n, read_select, upper_byte_select, comparator_high;
   logic [15:0] dac_code;
   logic track_hold, reference_on, eoc_n, result_bus_oe;
   logic [7:0] result_bus_out;
   wire [7:0] data_bus = result_bus_oe ? result_bus_out : 8'hzz;
   int miscompares = 0;
   int checks_done = 0;
   always #20 ref_clk = ~ref_clk;
   // Track-and-hold ahead of the comparator: the sample freezes once tracking stops
   always @(posedge ref_clk) begin
      if (track_hold) begin
         held <= analog;
      end
   end
   // Ideal comparator, so the search must land exactly on the held level
   assign comparator_high = held >= dac_code;
   sarrd_host u_host (.ref_clk(ref_clk), .eoc_n(eoc_n), .convert_strobe_n(convert_strobe_n),
      .read_select(read_select), .upper_byte_select(upper_byte_select));
   sarrd_top u_dut (.ref_clk(ref_clk), .rst(rst), .convert_strobe_n(convert_strobe_n),
      .read_select(read_select), .upper_byte_select(upper_byte_select), .comparator_high(comparator_high),
      .dac_code(dac_code), .track_hold(track_hold), .reference_on(reference_on), .eoc_n(eoc_n),
      .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      if (miscompares == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   task automatic ignored_edge();
      u_host.fall(1'h1);
      repeat (4) @(posedge ref_clk);
      #1;
      check(track_hold, 1'h0);
      check(data_bus, 8'hzz);
      u_host.release_bus();
   endtask : ignored_edge
   task automatic conv_read(input logic [15:0] level, input logic shut);
      int n;
      analog = level;
      u_host.fall(1'h0);
      repeat (4) @(posedge ref_clk);
      #1;
      check(track_hold, 1'h1);
      check(data_bus, 8'hzz);
      check(dac_code, sarrd_pkg::SAR_FIRST_TRIAL);
      u_host.settle();
      u_host.fall(shut);
      repeat (4) @(posedge ref_clk);
      #1;
      check(track_hold, 1'h0);
      check(data_bus, 8'hzz);
      // Channel switched once the sample is held; the result must not follow it
      analog = ~level;
      u_host.wait_eoc(n);
      check(eoc_n, 1'h0);
      check(n <= sarrd_pkg::CONV_MAX_CYCLES - 3, 1'h1);
      // A reading edge with the select low must neither drive nor restart
      u_host.fall(1'h0);
      repeat (3) @(posedge ref_clk);
      #1;
      check(track_hold, 1'h0);
      check(eoc_n, 1'h0);
      check(data_bus, 8'hzz);
      u_host.fall(1'h1);
      repeat (3) @(posedge ref_clk);
      #1;
      check(result_bus_oe, 1'h1);
      check(data_bus, level[7:0]);
      u_host.pick(1'h1);
      check(data_bus, level[15:8]);
      check(reference_on, !shut);
      u_host.release_bus();
      repeat (3) @(posedge ref_clk);
      #1;
      check(data_bus, 8'hzz);
      u_host.pick(1'h0);
      repeat (20) @(posedge ref_clk);
      #1;
      check({track_hold, result_bus_oe}, 2'h0);
      check(reference_on, !shut);
   endtask : conv_read
   initial begin
      repeat (12) @(posedge ref_clk);
      #1 rst = 1'h0;
      ignored_edge();
      conv_read(16'h0000, 1'h1);
      conv_read(16'hffff, 1'h0);
      conv_read(16'ha5c3, 1'h1);
      ignored_edge();
      test_done();
   end
   // Three conversions need well under a tenth of this span
   initial begin
      #200000;
      miscompares++;
      test_done();
   end
endmodule : tb
